// ===== config_port_bank_switch.sv
// Slave serial configuration port with mode control and two-bank switching.
// Assumes sys_clk is far faster than sclk, so pin edges are found by sampling.
//
// How it works
// [R1] Configuration needs select low and wake high; master drives clock, data in.
// [R2] Transfers are whole bytes and always open with a command byte.
// [R3] Only the first byte after a select falling edge is a command.
// [R4] Command holds count code 7:6, start address 5:1, direction bit 0.
// [R5] Count code 00,01,10,11 gives one, two, four, eight registers.
// [R6] Address advances by one after each data byte.
// [R7] Direction 0 reads onto MISO, direction 1 writes from MOSI.
// [R8] A byte is taken on its eighth falling clock edge; fragments are lost.
// [R9] Master toggles select between accesses and keeps gaps short without wake.
// [R10] Entering configuration leaves all register contents untouched.
// [R11] Receiver keeps its on or off state in configuration; no reception.
// [R12] While select stays low the machine stays in its one configuration state.
// [R13] Master leaves receive by a short select low pulse, then waits one frame.
// [R14] Master waits oscillator plus loop lock time after standby before access.
// [R15] Power-up starts in standby; master wakes, then selects to write.
// [R16] Bank switching happens only in receive mode.
// [R17] Secondary off picks primary; secondary only picks secondary; both alternate.
// [R18] The active bank flag reads the same from either bank.
// [R19] Direct control uses wake held high, oscillator off, never both banks.
// [R20] Under direct control the new bank takes effect when select rises.
// [R21] Under wake control with both banks set, each wakeup alternates banks.
// [R22] With both banks set, the flag toggles at each wake falling edge.
// [R23] After any serial access the alternating sequence restarts at primary.
// [R24] Standby entered with select high, wake low; left by select low, wake high.
// [R25] Bytes travel MSB first; MOSI sampled on rise, MISO changed on fall.
`timescale 1ns/10ps
module config_port_bank_switch
  import cfg_port_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 arst_n,
  input  wire logic                 sclk,
  input  wire logic                 mosi,
  input  wire logic                 configSelect_n,
  input  wire logic                 wakePin,
  input  wire logic                 spiEnable_n,
  input  wire logic                 autoWakeOscEn,
  input  wire logic                 primaryBankEn,
  input  wire logic                 secondaryBankEn,
  output logic                      miso,
  output logic                      misoOe_n,
  output logic                      cfgMode,
  output logic                      standbyMode,
  output logic                      receiverOn,
  output logic                      rxAccept,
  output logic                      activeBankFlag,
  output logic                      regWrStrobe,
  output logic      [ADDR_BITS-1:0] regWrAddr,
  output logic      [BYTE_BITS-1:0] regWrData
);

  logic [PIN_COUNT-1:0] pinS;
  logic                 sclkS;
  logic                 mosiS;
  logic                 csnS;
  logic                 wakeS;
  logic                 senS;
  logic                 sclkPrev_q;
  logic                 csnPrev_q;
  logic                 wakePrev_q;
  logic                 sclkRise;
  logic                 sclkFall;
  logic                 csnFall;
  logic                 wakeFall;
  mode_type             mode_q;
  logic                 cfgActive;
  logic                 byteDone;
  logic [2:0]           bitCnt_q;
  logic [BYTE_BITS-1:0] rxShift_q;
  logic                 expectCmd_q;
  logic                 dir_q;
  logic [ADDR_BITS-1:0] addr_q;
  logic [3:0]           remaining_q;
  logic                 readPhase_q;
  logic                 rdReq_q;
  logic                 rdValid_q;
  logic [ADDR_BITS-1:0] rdAddr_q;
  logic [BYTE_BITS-1:0] rdData;
  logic [BYTE_BITS-1:0] txShift_q;
  logic                 primEn_q;
  logic                 secEn_q;

  // Every pin from the master crosses into sys_clk through two flip-flops.
  pin_sync u_pin_sync (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .pinAsync ({spiEnable_n, wakePin, configSelect_n, mosi, sclk}),
    .pinSync  (pinS)
  );

  assign sclkS = pinS[PIN_SCLK];
  assign mosiS = pinS[PIN_MOSI];
  assign csnS  = pinS[PIN_CSN];
  assign wakeS = pinS[PIN_WAKE];
  assign senS  = pinS[PIN_SEN];

  // Previous samples of the synchronised pins, used to find their edges.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sclkPrev_q <= 1'b0;
      csnPrev_q  <= 1'b1;
      wakePrev_q <= 1'b0;
    end
    else
    begin
      sclkPrev_q <= sclkS;
      csnPrev_q  <= csnS;
      wakePrev_q <= wakeS;
    end
  end

  // Edge strobes last one sys_clk cycle each.
  assign sclkRise = sclkS & ~sclkPrev_q;
  assign sclkFall = ~sclkS & sclkPrev_q;
  assign csnFall  = ~csnS & csnPrev_q;
  assign wakeFall = ~wakeS & wakePrev_q;

  // Mode machine; power-up lands in standby because nothing else is safe
  // while the master's pins are still undefined.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_q <= MODE_STANDBY; // [R15]
    end
    else
    begin
      unique case (mode_q)
        MODE_STANDBY:
        begin
          if (!csnS && wakeS)
          begin
            mode_q <= MODE_CONFIG; // [R24] [R1]
          end
        end
        MODE_RECEIVE:
        begin
          if (!csnS && wakeS)
          begin
            mode_q <= MODE_CONFIG; // [R1]
          end
        end
        MODE_CONFIG:
        begin
          if (csnS)
          begin
            mode_q <= wakeS ? MODE_RECEIVE : MODE_STANDBY; // [R24]
          end
          else
          begin
            mode_q <= MODE_CONFIG; // [R12]
          end
        end
        default:
        begin
          mode_q <= MODE_STANDBY;
        end
      endcase
    end
  end

  // The shifter only runs inside configuration with the port enabled.
  assign cfgActive = (mode_q == MODE_CONFIG) && !csnS && !senS; // [R1]
  // A byte closes on its eighth falling edge only.
  assign byteDone = cfgActive && sclkFall && (bitCnt_q == LAST_BIT_IDX); // [R8] [R2]

  // Receive shifter and bit counter.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bitCnt_q  <= 3'h0;
      rxShift_q <= BYTE_RESET;
    end
    else if (csnFall || !cfgActive)
    begin
      bitCnt_q <= 3'h0; // [R8]
    end
    else
    begin
      if (sclkRise)
      begin
        rxShift_q <= {rxShift_q[BYTE_BITS-2:0], mosiS}; // [R25]
      end
      if (sclkFall)
      begin
        bitCnt_q <= bitCnt_q + 3'h1;
      end
    end
  end

  // Command decode and data byte sequencing. A partial byte left when select
  // rises never reaches byteDone, so it is simply dropped.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      expectCmd_q <= 1'b0;
      dir_q       <= DIR_READ;
      addr_q      <= ADDR_RESET;
      remaining_q <= COUNT_RESET;
      readPhase_q <= 1'b0;
      rdReq_q     <= 1'b0;
      rdAddr_q    <= ADDR_RESET;
      regWrStrobe <= 1'b0;
      regWrAddr   <= ADDR_RESET;
      regWrData   <= BYTE_RESET;
    end
    else
    begin
      rdReq_q     <= 1'b0;
      regWrStrobe <= 1'b0;
      if (csnFall)
      begin
        expectCmd_q <= 1'b1; // [R3]
        remaining_q <= COUNT_RESET;
        readPhase_q <= 1'b0;
      end
      else if (csnS)
      begin
        expectCmd_q <= 1'b0;
        readPhase_q <= 1'b0;
      end
      else if (byteDone && expectCmd_q)
      begin
        expectCmd_q <= 1'b0;
        dir_q       <= rxShift_q[CMD_DIR_POS]; // [R4]
        addr_q      <= rxShift_q[CMD_ADDR_MSB:CMD_ADDR_LSB]; // [R4]
        remaining_q <= decodeCount(rxShift_q[CMD_CNT_MSB:CMD_CNT_LSB]); // [R5]
        if (rxShift_q[CMD_DIR_POS] == DIR_READ)
        begin
          readPhase_q <= 1'b1; // [R7]
          rdReq_q     <= 1'b1;
          rdAddr_q    <= rxShift_q[CMD_ADDR_MSB:CMD_ADDR_LSB];
        end
      end
      else if (byteDone && (remaining_q != COUNT_RESET))
      begin
        remaining_q <= remaining_q - COUNT_ONE;
        addr_q      <= addr_q + ADDR_STEP; // [R6]
        if (dir_q == DIR_WRITE)
        begin
          regWrStrobe <= 1'b1; // [R7]
          regWrAddr   <= addr_q;
          regWrData   <= rxShift_q;
        end
        else if (remaining_q != COUNT_ONE)
        begin
          rdReq_q  <= 1'b1; // [R6]
          rdAddr_q <= addr_q + ADDR_STEP;
        end
        if (remaining_q == COUNT_ONE)
        begin
          readPhase_q <= 1'b0;
        end
      end
    end
  end

  // Only serial writes touch the store; mode entry itself writes nothing.
  reg_mem u_reg_mem (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .wrEn    (regWrStrobe), // [R10]
    .wrAddr  (regWrAddr),
    .wrData  (regWrData),
    .rdEn    (rdReq_q),
    .rdAddr  (rdAddr_q),
    .rdData  (rdData)
  );

  // Read data are loaded a few sys_clk cycles after the closing fall, well
  // before the master's next rising edge; this limits sclk to a few MHz.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdValid_q <= 1'b0;
      txShift_q <= BYTE_RESET;
      miso      <= 1'b0;
      misoOe_n  <= 1'b1;
    end
    else
    begin
      rdValid_q <= rdReq_q;
      misoOe_n  <= !(cfgActive && readPhase_q); // [R7]
      if (rdValid_q)
      begin
        txShift_q <= rdData;
        miso      <= rdData[BYTE_BITS-1]; // [R25]
      end
      else if (cfgActive && sclkFall)
      begin
        txShift_q <= {txShift_q[BYTE_BITS-2:0], 1'b0};
        miso      <= txShift_q[BYTE_BITS-2]; // [R25]
      end
    end
  end

  // Bank enables are taken when select rises, so a bank chosen during
  // configuration only becomes active on exit; both set restarts at primary.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      primEn_q       <= 1'b0;
      secEn_q        <= 1'b0;
      activeBankFlag <= BANK_PRIMARY;
    end
    else if ((mode_q == MODE_CONFIG) && csnS)
    begin
      primEn_q <= primaryBankEn; // [R20]
      secEn_q  <= secondaryBankEn;
      if (secondaryBankEn && !primaryBankEn)
      begin
        activeBankFlag <= BANK_SECONDARY; // [R17]
      end
      else
      begin
        activeBankFlag <= BANK_PRIMARY; // [R23] [R20]
      end
    end
    else if (mode_q == MODE_RECEIVE)
    begin
      if (!secEn_q)
      begin
        activeBankFlag <= BANK_PRIMARY; // [R16] [R17]
      end
      else if (!primEn_q)
      begin
        activeBankFlag <= BANK_SECONDARY; // [R17]
      end
      else if (wakeFall)
      begin
        // Each wake pin falling edge flips the bank for the next wakeup; the
        // autoWakeOscEn input is not used anywhere. A wake pin held
        // high never falls, so direct control never alternates.
        activeBankFlag <= ~activeBankFlag; // [R22] [R21] [R18] [R19]
      end
    end
  end

  // Receiver state and mode flags; configuration freezes the on/off state.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      receiverOn  <= 1'b0;
      rxAccept    <= 1'b0;
      cfgMode     <= 1'b0;
      standbyMode <= 1'b1;
    end
    else
    begin
      cfgMode     <= (mode_q == MODE_CONFIG); // [R12]
      standbyMode <= (mode_q == MODE_STANDBY);
      rxAccept    <= (mode_q == MODE_RECEIVE) && wakeS; // [R11]
      if (mode_q == MODE_RECEIVE)
      begin
        receiverOn <= wakeS;
      end
      else if (mode_q == MODE_STANDBY)
      begin
        receiverOn <= 1'b0;
      end
      else
      begin
        receiverOn <= receiverOn; // [R11]
      end
    end
  end

endmodule

// ===== cfg_port_pkg.sv
// Shared constants, types and decode helpers for the serial configuration port.
// Assumes every user is clocked by sys_clk and imports the whole package.
package cfg_port_pkg;

  // Serial framing.
  localparam int BYTE_BITS = 8;
  localparam logic [2:0] LAST_BIT_IDX = 3'h7;
  localparam int ADDR_BITS = 5;
  localparam int REG_COUNT = 32;

  // Command byte field positions.
  localparam int CMD_CNT_MSB  = 7;
  localparam int CMD_CNT_LSB  = 6;
  localparam int CMD_ADDR_MSB = 5;
  localparam int CMD_ADDR_LSB = 1;
  localparam int CMD_DIR_POS  = 0;

  // Direction encodings of the command byte.
  localparam logic DIR_READ  = 1'b0;
  localparam logic DIR_WRITE = 1'b1;

  // Address advance after each data byte.
  localparam logic [4:0] ADDR_STEP = 5'h01;

  // Synchronised pin vector layout.
  localparam int PIN_COUNT = 5;
  localparam int PIN_SCLK  = 0;
  localparam int PIN_MOSI  = 1;
  localparam int PIN_CSN   = 2;
  localparam int PIN_WAKE  = 3;
  localparam int PIN_SEN   = 4;

  // Pins idle at a deselected, asleep level after reset.
  localparam logic [4:0] PIN_RESET = 5'h14;

  // Active bank flag values: one means the primary bank.
  localparam logic BANK_PRIMARY   = 1'b1;
  localparam logic BANK_SECONDARY = 1'b0;

  // Reset values.
  localparam logic [7:0] BYTE_RESET  = 8'h00;
  localparam logic [4:0] ADDR_RESET  = 5'h00;
  localparam logic [3:0] COUNT_RESET = 4'h0;
  localparam logic [3:0] COUNT_ONE   = 4'h1;

  typedef enum logic [1:0] {MODE_STANDBY, MODE_RECEIVE, MODE_CONFIG} mode_type;

  // Turns the two-bit count code into the number of registers accessed.
  function automatic logic [3:0] decodeCount(input logic [1:0] code);
    logic [3:0] n;
    n = 4'h1;
    unique case (code)
      2'h0: n = 4'h1;
      2'h1: n = 4'h2;
      2'h2: n = 4'h4;
      2'h3: n = 4'h8;
    endcase
    return n;
  endfunction

endpackage

// ===== pin_sync.sv
// Two-stage synchroniser for the asynchronous pins of the configuration port.
// Assumes the pins change slowly against sys_clk; each bit is treated alone.
`timescale 1ns/10ps
module pin_sync
  import cfg_port_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 arst_n,
  input  wire logic [PIN_COUNT-1:0] pinAsync,
  output logic      [PIN_COUNT-1:0] pinSync
);

  logic [PIN_COUNT-1:0] meta_q;

  // The first stage feeds only the second stage, to keep metastability contained.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_q  <= PIN_RESET;
      pinSync <= PIN_RESET;
    end
    else
    begin
      meta_q  <= pinAsync;
      pinSync <= meta_q;
    end
  end

endmodule

// ===== reg_mem.sv
// Register store of the configuration port: one write port, one read port.
// Assumes requests come from sys_clk logic; read data appear one edge later.
`timescale 1ns/10ps
module reg_mem
  import cfg_port_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 arst_n,
  input  wire logic                 wrEn,
  input  wire logic [ADDR_BITS-1:0] wrAddr,
  input  wire logic [BYTE_BITS-1:0] wrData,
  input  wire logic                 rdEn,
  input  wire logic [ADDR_BITS-1:0] rdAddr,
  output logic      [BYTE_BITS-1:0] rdData
);

  logic [BYTE_BITS-1:0] store [REG_COUNT];

  // Storage has no reset, so entering configuration never disturbs contents.
  always_ff @(posedge sys_clk)
  begin
    if (wrEn)
    begin
      store[wrAddr] <= wrData;
    end
  end

  // Read data are registered so the serial logic sees a stable byte.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdData <= BYTE_RESET;
    end
    else if (rdEn)
    begin
      rdData <= store[rdAddr];
    end
  end

endmodule

// ===== config_port_bank_switch_checker.sv
// Concurrent checks on the ports of the configuration port with bank switching.
// Assumes one sys_clk domain and slow asynchronous pins seen through the design's synchroniser.
`timescale 1ns/10ps
module config_port_bank_switch_checker
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic configSelect_n,
  input wire logic wakePin,
  input wire logic primaryBankEn,
  input wire logic secondaryBankEn,
  input wire logic cfgMode,
  input wire logic standbyMode,
  input wire logic receiverOn,
  input wire logic rxAccept,
  input wire logic activeBankFlag,
  input wire logic regWrStrobe
);
  // Windows allow for the two synchroniser stages plus edge detection.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  cfg_entry_a: assert property ($fell(configSelect_n) && wakePin |-> ##[1:6] cfgMode)
    else $error("Select with wake high did not enter configuration.");
  sleep_ignore_a: assert property ((standbyMode && !wakePin) [*5] |-> !cfgMode)
    else $error("Configuration entered while asleep.");
  cfg_hold_a: assert property (cfgMode && !configSelect_n |=> cfgMode)
    else $error("Configuration state left while select low.");
  cfg_exit_a: assert property (configSelect_n [*6] |-> !cfgMode)
    else $error("Configuration kept after select rose.");
  no_rx_a: assert property (cfgMode |-> !rxAccept)
    else $error("Reception accepted in configuration.");
  rx_freeze_a: assert property (cfgMode && $past(cfgMode) |-> $stable(receiverOn))
    else $error("Receiver state changed in configuration.");
  // The flag may move on the exit edge, while cfgMode still reads high for one more cycle,
  // so the check stands down once the select rise has had three cycles to cross.
  cfg_bank_a: assert property (cfgMode && $past(cfgMode)
      && !$past(configSelect_n, 3) |-> $stable(activeBankFlag))
    else $error("Active bank changed in configuration.");
  bank_exit_a: assert property ($fell(cfgMode) |->
      ##[0:2] (activeBankFlag == (primaryBankEn || !secondaryBankEn)))
    else $error("Wrong active bank after configuration.");
  wake_toggle_a: assert property (rxAccept && primaryBankEn && secondaryBankEn && $fell(wakePin)
      |-> ##[1:5] $changed(activeBankFlag))
    else $error("Bank did not alternate at wake fall.");
  wr_pulse_a: assert property (regWrStrobe |-> cfgMode ##1 !regWrStrobe)
    else $error("Write strobe outside configuration or too long.");
endmodule

bind config_port_bank_switch config_port_bank_switch_checker chk_u (.sys_clk(sys_clk),
  .arst_n(arst_n), .configSelect_n(configSelect_n), .wakePin(wakePin),
  .primaryBankEn(primaryBankEn), .secondaryBankEn(secondaryBankEn), .cfgMode(cfgMode),
  .standbyMode(standbyMode), .receiverOn(receiverOn), .rxAccept(rxAccept),
  .activeBankFlag(activeBankFlag), .regWrStrobe(regWrStrobe));

// ===== spi_master_model.sv
// Behavioural microcontroller acting as serial master of the configuration port.
// Assumes the testbench fills wrBuf before an access and reads rdBuf after it.
`timescale 1ns/10ps
module spi_master_model
(
  output logic      sclk,
  output logic      mosi,
  output logic      configSelect_n,
  output logic      wakePin,
  output logic      spiEnable_n,
  input  wire logic miso,
  input  wire logic misoOe_n
);
  localparam realtime HALF = 62.5ns;
  localparam realtime LOCK_WAIT = 2us; // Lock time of oscillator and loop; value is arbitrary.
  localparam realtime DIG_PERIOD = 1us; // One digital clock period; value is arbitrary.
  localparam realtime ID_TIME = 4us; // Length of one received identifier; value is arbitrary.
  logic [7:0] wrBuf [8];
  logic [7:0] rdBuf [8];
  // Pins start deselected and asleep; the clock is parked low outside frames.
  initial
  begin
    sclk = 1'b0;
    mosi = 1'b0;
    configSelect_n = 1'b1;
    wakePin = 1'b0;
    spiEnable_n = 1'b1;
  end
  // Every change of select or wake made by this task is followed by the lock wait before any access.
  task automatic setPins(input logic csn, input logic wake);
    configSelect_n = csn;
    wakePin = wake;
    #LOCK_WAIT;
  endtask
  // Leaving receive: a short select pulse restarts the state machine, then select stays high.
  task automatic leaveReceive();
    configSelect_n = 1'b0;
    #DIG_PERIOD;
    configSelect_n = 1'b1;
    #ID_TIME;
  endtask
  // MSB first; miso is read late in the high phase because the device updates it slowly.
  task automatic shiftByte(input logic [7:0] tx, input int nBits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nBits; i--)
    begin
      mosi = tx[i];
      #HALF;
      sclk = 1'b1;
      #(HALF - 2ns);
      rx[i] = misoOe_n ? 1'bx : miso;
      #2ns;
      sclk = 1'b0;
    end
    mosi = ~mosi; // A released data line must not keep showing the last bit.
  endtask
  // One framed access: command, data units, an optional fragment, then select high again.
  task automatic access(input logic [7:0] cmd, input int nBytes, input int tailBits);
    logic [7:0] rx;
    configSelect_n = 1'b0;
    spiEnable_n = 1'b0;
    #300ns;
    shiftByte(cmd, 8, rx);
    for (int k = 0; k < nBytes; k++)
    begin
      shiftByte((k < 8) ? wrBuf[k] : 8'h5a, 8, rx);
      if (k < 8)
        rdBuf[k] = rx;
    end
    if (tailBits > 0)
      shiftByte(8'hff, tailBits, rx);
    #300ns;
    configSelect_n = 1'b1;
    spiEnable_n = 1'b1;
    #1us;
  endtask
endmodule

// ===== config_port_bank_switch_tb.sv
// Self-checking testbench of the configuration port with bank switching.
// Assumes the master model drives the serial pins and the bench drives the bank enables.
`timescale 1ns/10ps
module config_port_bank_switch_tb;
  import cfg_port_pkg::*;
  logic sys_clk, arst_n, autoWakeOscEn, primaryBankEn, secondaryBankEn;
  wire logic sclk, mosi, configSelect_n, wakePin, spiEnable_n, miso, misoOe_n;
  wire logic cfgMode, standbyMode, receiverOn, rxAccept, activeBankFlag, regWrStrobe;
  wire logic [ADDR_BITS-1:0] regWrAddr;
  wire logic [BYTE_BITS-1:0] regWrData;
  logic [12:0] wrLog [$];
  logic [7:0] mem [32];
  int failures = 0;
  int nCompared = 0;
  config_port_bank_switch dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .sclk(sclk), .mosi(mosi),
    .configSelect_n(configSelect_n), .wakePin(wakePin), .spiEnable_n(spiEnable_n),
    .autoWakeOscEn(autoWakeOscEn), .primaryBankEn(primaryBankEn),
    .secondaryBankEn(secondaryBankEn), .miso(miso), .misoOe_n(misoOe_n), .cfgMode(cfgMode),
    .standbyMode(standbyMode), .receiverOn(receiverOn), .rxAccept(rxAccept),
    .activeBankFlag(activeBankFlag), .regWrStrobe(regWrStrobe), .regWrAddr(regWrAddr),
    .regWrData(regWrData));
  spi_master_model master_u (.sclk(sclk), .mosi(mosi), .configSelect_n(configSelect_n),
    .wakePin(wakePin), .spiEnable_n(spiEnable_n), .miso(miso), .misoOe_n(misoOe_n));
  // Clock of 100 MHz.
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Every written unit is logged as address and data.
  always @(posedge sys_clk)
    if (regWrStrobe === 1'b1)
      wrLog.push_back({regWrAddr, regWrData});
  task automatic checkBit(input logic got, input logic exp);
    nCompared++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic checkByte(input logic [7:0] got, input logic [7:0] exp);
    nCompared++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Sends one spare unit beyond the count, or, with a fragment, stops one unit short
  // and ends on the fragment inside the count; neither spare nor fragment may be written.
  task automatic runWrite(input logic [1:0] code, input logic [4:0] addr, input int tail);
    int n;
    int nExp;
    logic [12:0] got;
    n = 1 << code;
    nExp = (tail > 0) ? n - 1 : n;
    wrLog.delete();
    for (int k = 0; k < 8; k++)
      master_u.wrBuf[k] = 8'ha0 + 8'(code * 16 + k);
    master_u.access({code, addr, DIR_WRITE}, (tail > 0) ? nExp : n + 1, tail);
    checkByte(8'(wrLog.size()), 8'(nExp));
    for (int k = 0; k < nExp; k++)
    begin
      got = wrLog.pop_front();
      mem[addr + 5'(k)] = master_u.wrBuf[k];
      checkByte({3'h0, got[12:8]}, {3'h0, addr + 5'(k)});
      checkByte(got[7:0], master_u.wrBuf[k]);
    end
  endtask
  task automatic runRead(input logic [1:0] code, input logic [4:0] addr);
    wrLog.delete();
    master_u.access({code, addr, DIR_READ}, 1 << code, 0);
    checkByte(8'(wrLog.size()), 8'h00);
    for (int k = 0; k < (1 << code); k++)
      checkByte(master_u.rdBuf[k], mem[addr + 5'(k)]);
  endtask
  task automatic setBanks(input logic prim, input logic sec);
    @(posedge sys_clk);
    primaryBankEn <= prim;
    secondaryBankEn <= sec;
    // Step off the edge so the next pin change never races the synchroniser.
    #1;
  endtask
  task report_and_stop;
    $display("Compared %0d, mismatches %0d", nCompared, failures);
    if (failures == 0 && nCompared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // The tests take well under 100 us; this limit only cuts a hang short.
  initial
  begin
    #400us;
    failures++;
    report_and_stop();
  end
  initial
  begin
    arst_n = 1'b0;
    autoWakeOscEn = 1'b0;
    primaryBankEn = 1'b1;
    secondaryBankEn = 1'b0;
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    checkBit(standbyMode, 1'b1);
    checkBit(cfgMode, 1'b0);
    checkBit(activeBankFlag, BANK_PRIMARY);
    master_u.setPins(1'b0, 1'b0);
    checkBit(cfgMode, 1'b0);
    master_u.setPins(1'b1, 1'b0);
    master_u.setPins(1'b1, 1'b1);
    checkBit(standbyMode, 1'b1);
    runWrite(2'h1, 5'h00, 4);
    checkBit(standbyMode, 1'b0);
    checkBit(rxAccept, 1'b1);
    master_u.leaveReceive();
    checkBit(cfgMode, 1'b0);
    checkBit(rxAccept, 1'b1);
    checkBit(activeBankFlag, BANK_PRIMARY);
    runWrite(2'h1, 5'h02, 0);
    runWrite(2'h2, 5'h08, 0);
    runWrite(2'h3, 5'h1c, 0);
    checkBit(activeBankFlag, BANK_PRIMARY);
    runRead(2'h3, 5'h1c);
    setBanks(1'b0, 1'b1);
    runRead(2'h0, 5'h08);
    checkBit(activeBankFlag, BANK_SECONDARY);
    setBanks(1'b1, 1'b1);
    runWrite(2'h0, 5'h10, 0);
    checkBit(activeBankFlag, BANK_PRIMARY);
    master_u.setPins(1'b1, 1'b0);
    checkBit(activeBankFlag, BANK_SECONDARY);
    checkBit(receiverOn, 1'b0);
    checkBit(rxAccept, 1'b0);
    master_u.setPins(1'b1, 1'b1);
    checkBit(receiverOn, 1'b1);
    runRead(2'h0, 5'h10);
    checkBit(activeBankFlag, BANK_PRIMARY);
    master_u.setPins(1'b1, 1'b0);
    master_u.setPins(1'b1, 1'b1);
    master_u.setPins(1'b1, 1'b0);
    checkBit(activeBankFlag, BANK_PRIMARY);
    report_and_stop();
  end
endmodule
